// ### core/gmx_defs.vh
// Constants for the pin alternate-function multiplexer
`ifndef GMX_DEFS_VH
`define GMX_DEFS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define GMX_IDX_DIR 12'h08a
`define GMX_IDX_SEL_B 12'h08d
`define GMX_IDX_SEL_C 12'h08e
`define GMX_ADDR_DIR (`GMX_IDX_DIR * 12'h004)
`define GMX_ADDR_SEL_B (`GMX_IDX_SEL_B * 12'h004)
`define GMX_ADDR_SEL_C (`GMX_IDX_SEL_C * 12'h004)

// ----------------------------------------
// Field positions
// ----------------------------------------
`define GMX_FW 4
`define GMX_F_P4 0
`define GMX_F_P5 4
`define GMX_F_P6 8
`define GMX_F_P8 0
`define GMX_F_P9 4
`define GMX_DIR_LSB 0
`define GMX_LVL_LSB 8
`define GMX_DIR_RST 5'h00
`define GMX_NPIN 5
`define GMX_OE_RST 5'h1f

// ----------------------------------------
// Select codes, pin four
// ----------------------------------------
`define GMX_P4I_MANRST 4'h1
`define GMX_P4I_FLASH 4'h2
`define GMX_P4I_HIBL 4'h3
`define GMX_P4I_MASK 4'h4
`define GMX_P4I_CHIPRST 4'h5
`define GMX_P4O_MEMRESET 4'h1
`define GMX_P4O_DATAAV 4'h2
`define GMX_P4O_FLASH 4'h3
`define GMX_P4O_VCCF 4'h4
`define GMX_P4O_MICSHORT 4'h5
`define GMX_P4O_MICDETECT 4'ha

// ----------------------------------------
// Select codes, pin five
// ----------------------------------------
`define GMX_P5I_LPR1 4'h1
`define GMX_P5I_FRAME 4'h2
`define GMX_P5I_HIBE 4'h3
`define GMX_P5I_PWROFF 4'h4
`define GMX_P5I_HIBL 4'h5
`define GMX_P5O_DEVCLK 4'h1
`define GMX_P5O_FRAME 4'h2
`define GMX_P5O_CLK32K 4'h3
`define GMX_P5O_BATTF 4'h4
`define GMX_P5O_MICSHORT 4'h5
`define GMX_P5O_DATAAV 4'h6
`define GMX_P5O_OPCLK 4'h7
`define GMX_P5O_UV5 4'h8
`define GMX_P5O_CLK5 4'h9
`define GMX_P5O_MICDETECT 4'ha

// ----------------------------------------
// Select codes, pin six
// ----------------------------------------
`define GMX_P6I_LPR2 4'h1
`define GMX_P6I_FLASH 4'h2
`define GMX_P6I_HIBE 4'h3
`define GMX_P6I_HIBL 4'h4
`define GMX_P6O_MEMRESET 4'h1
`define GMX_P6O_DATAAV 4'h2
`define GMX_P6O_RTC 4'h3
`define GMX_P6O_MICDETECT 4'h4
`define GMX_P6O_MICSHORT 4'h5
`define GMX_P6O_FRAMEB 4'h6

// ----------------------------------------
// Select codes, pins eight and nine
// ----------------------------------------
`define GMX_P8I_MANRST 4'h1
`define GMX_P8I_BCLK 4'h2
`define GMX_P8I_PWROFF 4'h3
`define GMX_P8I_HIBE 4'h4
`define GMX_P8O_VCCF 4'h1
`define GMX_P8O_BCLK 4'h2
`define GMX_P8O_BATTF 4'h3
`define GMX_P8O_RST 4'h4
`define GMX_P9I_ALIVE 4'h1
`define GMX_P9I_MASK 4'h2
`define GMX_P9I_PWROFF 4'h3
`define GMX_P9I_HIBL 4'h4
`define GMX_P9O_VCCF 4'h1
`define GMX_P9O_LINE 4'h2
`define GMX_P9O_BATTF 4'h3
`define GMX_P9O_MEMRESET 4'h4

`endif

// ### core/gmx_pin_mux.v
// Alternate-function multiplexer for pins four, five, six, eight and nine
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/10ps
`include "gmx_defs.vh"
module gmx_pin_mux #(
  parameter [15:0] MASK_DEFAULT_B = 16'h0000,
  parameter [15:0] MASK_DEFAULT_C = 16'h0000
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Power state machine reset request
  input wire psm_reset_req,
  // Pads, index 0..4 = pins 4, 5, 6, 8, 9
  input wire [4:0] pin_in,
  output reg [4:0] pin_out,
  output reg [4:0] pin_oe_n,
  // Plain GPIO path
  input wire [4:0] gpio_out,
  output reg [4:0] gpio_in,
  // Internal sources for output functions
  input wire device_clock,
  input wire adc_frame_clock,
  input wire clk_32k,
  input wire battery_fault_n,
  input wire mic_short,
  input wire mic_detect,
  input wire adc_data_avail,
  input wire codec_output_clock,
  input wire conv5_undervoltage,
  input wire conv5_clock,
  input wire memory_reset_n,
  input wire flash_out,
  input wire supply_fault_n,
  input wire rtc_signal,
  input wire line_above_battery,
  input wire reset_n,
  input wire adc_bit_clock,
  // Input functions toward the device
  output reg low_power_req_one,
  output reg low_power_req_two,
  output reg flash_trigger,
  output reg hibernate_edge,
  output reg hibernate_level,
  output reg power_off_req,
  output reg manual_reset_n,
  output reg mask_req,
  output reg chip_reset_req,
  output reg host_alive_pulse,
  output reg adc_frame_clock_in,
  output reg adc_bit_clock_in
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [15:0] sel_b;
  reg [15:0] sel_c;
  reg [4:0] dir;
  reg [4:0] sync1;
  reg [4:0] lvl;
  reg [4:0] lvl_d;

  // Select fields; the direction bit decides input or output use
  wire [3:0] s4 = sel_b[`GMX_F_P4 +: `GMX_FW];
  wire [3:0] s5 = sel_b[`GMX_F_P5 +: `GMX_FW];
  wire [3:0] s6 = sel_b[`GMX_F_P6 +: `GMX_FW];
  wire [3:0] s8 = sel_c[`GMX_F_P8 +: `GMX_FW];
  wire [3:0] s9 = sel_c[`GMX_F_P9 +: `GMX_FW];
  // Rising edge seen between the second and third stage
  wire [4:0] edge_up = lvl & ~lvl_d;
  wire adc_frame_clock_inv = ~adc_frame_clock;

  // Field selected, pin configured as input
  function routed;
    input [3:0] s;
    input [3:0] c;
    input d;
    begin
      routed = ~d & (s == c);
    end
  endfunction

  // ----------------------------------------
  // Pad synchronisers
  // ----------------------------------------
  // Pads reset low, their idle level, so no false edge follows reset
  // Only the second and third stages feed logic; the first may be metastable
  genvar i;
  generate
    for (i = 0; i < `GMX_NPIN; i = i + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[i] <= 1'b0;
          lvl[i] <= 1'b0;
          lvl_d[i] <= 1'b0;
        end else begin
          sync1[i] <= pin_in[i];
          lvl[i] <= sync1[i];
          lvl_d[i] <= lvl[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Input routing
  // ----------------------------------------
  // Several pins may feed one function; active-high ones OR, resets AND
  // A pin set as output never feeds an input function
  // Manual reset is active low: a low routed pad asserts it
  reg next_lpr1;
  reg next_lpr2;
  reg next_flash;
  reg next_hibe;
  reg next_hibl;
  reg next_pwroff;
  reg next_manrst_n;
  reg next_mask;
  reg next_chiprst;
  reg next_alive;
  reg next_frame;
  reg next_bclk;

  always @* begin
    next_lpr1 = routed(s5, `GMX_P5I_LPR1, dir[1]) & lvl[1];
    next_frame = routed(s5, `GMX_P5I_FRAME, dir[1]) & lvl[1];
    next_lpr2 = routed(s6, `GMX_P6I_LPR2, dir[2]) & lvl[2];
    next_flash = (routed(s6, `GMX_P6I_FLASH, dir[2]) & lvl[2])
               | (routed(s4, `GMX_P4I_FLASH, dir[0]) & lvl[0]);
    next_hibe = (routed(s6, `GMX_P6I_HIBE, dir[2]) & edge_up[2])
              | (routed(s5, `GMX_P5I_HIBE, dir[1]) & edge_up[1])
              | (routed(s8, `GMX_P8I_HIBE, dir[3]) & edge_up[3]);
    next_hibl = (routed(s6, `GMX_P6I_HIBL, dir[2]) & lvl[2])
              | (routed(s5, `GMX_P5I_HIBL, dir[1]) & lvl[1])
              | (routed(s4, `GMX_P4I_HIBL, dir[0]) & lvl[0])
              | (routed(s9, `GMX_P9I_HIBL, dir[4]) & lvl[4]);
    next_pwroff = (routed(s5, `GMX_P5I_PWROFF, dir[1]) & lvl[1])
                | (routed(s8, `GMX_P8I_PWROFF, dir[3]) & lvl[3])
                | (routed(s9, `GMX_P9I_PWROFF, dir[4]) & lvl[4]);
    next_manrst_n = ~((routed(s4, `GMX_P4I_MANRST, dir[0]) & ~lvl[0])
                    | (routed(s8, `GMX_P8I_MANRST, dir[3]) & ~lvl[3]));
    next_mask = (routed(s4, `GMX_P4I_MASK, dir[0]) & lvl[0])
              | (routed(s9, `GMX_P9I_MASK, dir[4]) & lvl[4]);
    next_chiprst = routed(s4, `GMX_P4I_CHIPRST, dir[0]) & lvl[0];
    next_alive = routed(s9, `GMX_P9I_ALIVE, dir[4]) & lvl[4];
    next_bclk = routed(s8, `GMX_P8I_BCLK, dir[3]) & lvl[3];
  end

  // Outputs reset to their inactive levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_req_one <= 1'b0;
      low_power_req_two <= 1'b0;
      flash_trigger <= 1'b0;
      hibernate_edge <= 1'b0;
      hibernate_level <= 1'b0;
      power_off_req <= 1'b0;
      manual_reset_n <= 1'b1;
      mask_req <= 1'b0;
      chip_reset_req <= 1'b0;
      host_alive_pulse <= 1'b0;
      adc_frame_clock_in <= 1'b0;
      adc_bit_clock_in <= 1'b0;
      gpio_in <= 5'h00;
    end else begin
      low_power_req_one <= next_lpr1;
      low_power_req_two <= next_lpr2;
      flash_trigger <= next_flash;
      hibernate_edge <= next_hibe;
      hibernate_level <= next_hibl;
      power_off_req <= next_pwroff;
      manual_reset_n <= next_manrst_n;
      mask_req <= next_mask;
      chip_reset_req <= next_chiprst;
      host_alive_pulse <= next_alive;
      adc_frame_clock_in <= next_frame;
      adc_bit_clock_in <= next_bclk;
      gpio_in <= lvl;
    end
  end

  // ----------------------------------------
  // Output routing
  // ----------------------------------------
  // Clocks pass through one flop, so they are sampled at pclk rate
  // Reserved codes fall back to the plain GPIO value
  reg [4:0] next_out;

  always @* begin
    next_out = gpio_out;
    case (s4)
      `GMX_P4O_MEMRESET: next_out[0] = memory_reset_n;
      `GMX_P4O_DATAAV: next_out[0] = adc_data_avail;
      `GMX_P4O_FLASH: next_out[0] = flash_out;
      `GMX_P4O_VCCF: next_out[0] = supply_fault_n;
      `GMX_P4O_MICSHORT: next_out[0] = mic_short;
      `GMX_P4O_MICDETECT: next_out[0] = mic_detect;
      default: next_out[0] = gpio_out[0];
    endcase
    case (s5)
      `GMX_P5O_DEVCLK: next_out[1] = device_clock;
      `GMX_P5O_FRAME: next_out[1] = adc_frame_clock;
      `GMX_P5O_CLK32K: next_out[1] = clk_32k;
      `GMX_P5O_BATTF: next_out[1] = battery_fault_n;
      `GMX_P5O_MICSHORT: next_out[1] = mic_short;
      `GMX_P5O_DATAAV: next_out[1] = adc_data_avail;
      `GMX_P5O_OPCLK: next_out[1] = codec_output_clock;
      `GMX_P5O_UV5: next_out[1] = conv5_undervoltage;
      `GMX_P5O_CLK5: next_out[1] = conv5_clock;
      `GMX_P5O_MICDETECT: next_out[1] = mic_detect;
      default: next_out[1] = gpio_out[1];
    endcase
    case (s6)
      `GMX_P6O_MEMRESET: next_out[2] = memory_reset_n;
      `GMX_P6O_DATAAV: next_out[2] = adc_data_avail;
      `GMX_P6O_RTC: next_out[2] = rtc_signal;
      `GMX_P6O_MICDETECT: next_out[2] = mic_detect;
      `GMX_P6O_MICSHORT: next_out[2] = mic_short;
      `GMX_P6O_FRAMEB: next_out[2] = adc_frame_clock_inv;
      default: next_out[2] = gpio_out[2];
    endcase
    case (s8)
      `GMX_P8O_VCCF: next_out[3] = supply_fault_n;
      `GMX_P8O_BCLK: next_out[3] = adc_bit_clock;
      `GMX_P8O_BATTF: next_out[3] = battery_fault_n;
      `GMX_P8O_RST: next_out[3] = reset_n;
      default: next_out[3] = gpio_out[3];
    endcase
    case (s9)
      `GMX_P9O_VCCF: next_out[4] = supply_fault_n;
      `GMX_P9O_LINE: next_out[4] = line_above_battery;
      `GMX_P9O_BATTF: next_out[4] = battery_fault_n;
      `GMX_P9O_MEMRESET: next_out[4] = memory_reset_n;
      default: next_out[4] = gpio_out[4];
    endcase
  end

  // Reset releases every pad; the direction register turns drivers on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 5'h00;
      pin_oe_n <= `GMX_OE_RST;
    end else begin
      pin_out <= next_out;
      pin_oe_n <= ~dir;
    end
  end

  // ----------------------------------------
  // APB register access
  // ----------------------------------------
  // One wait state: pready rises on the second access-phase cycle
  // Register map, one word each, bits above 15 read zero:
  //   direction: 4:0 pin drives when set, 12:8 synced pad levels, read-only
  //   select b: pins four, five, six; pin seven stored only
  //   select c: pins eight, nine; pins ten and eleven stored only
  // Unmapped offsets read zero and raise pslverr without writing
  // Full address compare, so no register has an alias
  wire hit_dir = (paddr == `GMX_ADDR_DIR);
  wire hit_b = (paddr == `GMX_ADDR_SEL_B);
  wire hit_c = (paddr == `GMX_ADDR_SEL_C);
  wire hit = hit_dir | hit_b | hit_c;
  wire wr_go = psel & penable & pready & pwrite;
  wire acc_first = psel & penable & ~pready;

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    if (hit_b) begin
      next_rdata[15:0] = sel_b;
    end else if (hit_c) begin
      next_rdata[15:0] = sel_c;
    end else if (hit_dir) begin
      next_rdata[`GMX_DIR_LSB +: `GMX_NPIN] = dir;
      next_rdata[`GMX_LVL_LSB +: `GMX_NPIN] = lvl;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      // A held access retriggers the one-cycle pready pulse every other cycle
      pready <= 1'b0;
      if (acc_first) begin
        pready <= 1'b1;
        pslverr <= ~hit;
        prdata <= pwrite ? 32'h00000000 : next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // Fields of pins seven, ten and eleven are kept but route nothing
  // Mask-option defaults; the state machine reload beats a bus write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_b <= MASK_DEFAULT_B;
      sel_c <= MASK_DEFAULT_C;
      dir <= `GMX_DIR_RST;
    end else if (psm_reset_req) begin
      sel_b <= MASK_DEFAULT_B;
      sel_c <= MASK_DEFAULT_C;
      dir <= `GMX_DIR_RST;
    end else if (wr_go) begin
      if (hit_b) begin
        sel_b <= pwdata[15:0];
      end
      if (hit_c) begin
        sel_c <= pwdata[15:0];
      end
      if (hit_dir) begin
        dir <= pwdata[`GMX_DIR_LSB +: `GMX_NPIN];
      end
    end
  end

endmodule

// ### tb/gmx_pin_mux_checker.sv
// Concurrent checks on the multiplexer ports
`timescale 1ns/10ps
`include "gmx_defs.vh"
module gmx_pin_mux_checker (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pads and events
  input wire psm_reset_req,
  input wire [4:0] pin_oe_n,
  input wire hibernate_edge
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire map_ok = paddr == `GMX_ADDR_DIR || paddr == `GMX_ADDR_SEL_B || paddr == `GMX_ADDR_SEL_C;
  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    !pready ##1 pready;
  endsequence
  property p_wait;
    s_setup |=> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("pready late or early");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_acc;
    pready |-> psel && penable;
  endproperty
  a_acc: assert property (p_acc) else $error("pready outside access");
  property p_unmap;
    pready && !map_ok |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_map;
    pready && map_ok |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped refused");
  property p_upper;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_wdata;
    pready && pwrite |-> prdata == 32'h00000000;
  endproperty
  a_wdata: assert property (p_wdata) else $error("write returned data");
  // ----------------------------------------
  // Pads
  // ----------------------------------------
  property p_psm;
    psm_reset_req && !psel |-> ##2 pin_oe_n == 5'h1f;
  endproperty
  a_psm: assert property (p_psm) else $error("pads still driven");
  property p_edge;
    hibernate_edge |=> !hibernate_edge;
  endproperty
  a_edge: assert property (p_edge) else $error("edge event too long");
endmodule
bind gmx_pin_mux gmx_pin_mux_checker i_gmx_pin_mux_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .psm_reset_req, .pin_oe_n, .hibernate_edge);

// ### tb/testbench.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/10ps
`include "gmx_defs.vh"
module testbench;
  // ----------------------------------------
  // Stimulus and instance
  // ----------------------------------------
  localparam [15:0] DEF_B = 16'h0021;
  localparam [15:0] DEF_C = 16'h0043;
  // Input cases: bank, select word, pin, function index (b = edge event)
  localparam logic [27:0] TI [22] = '{28'h0000105, 28'h0000202, 28'h0000303,
    28'h0000406, 28'h0000507, 28'h0001010, 28'h0002019, 28'h000301b, 28'h0004014,
    28'h0005013, 28'h0010021, 28'h0020022, 28'h003002b, 28'h0040023, 28'h1000135,
    28'h100023a, 28'h1000334, 28'h100043b, 28'h1001048, 28'h1002046, 28'h1003044,
    28'h1004043};
  // Output cases: bank, select word, pin, source (80 = inverted, ff = plain pin)
  localparam logic [31:0] TO [35] = '{32'h0000100a, 32'h00002005, 32'h0000300b,
    32'h0000400c, 32'h00005004, 32'h0000a009, 32'h0000b0ff, 32'h00010100, 32'h00020101,
    32'h00030102, 32'h00040103, 32'h00050104, 32'h00060105, 32'h00070106, 32'h00080107,
    32'h00090108, 32'h000a0109, 32'h000f01ff, 32'h0010020a, 32'h00200205, 32'h0030020d,
    32'h00400209, 32'h00500204, 32'h00600281, 32'h007002ff, 32'h1000130c, 32'h10002310,
    32'h10003303, 32'h1000430f, 32'h100053ff, 32'h1001040c, 32'h1002040e, 32'h10030403,
    32'h1004040a, 32'h100504ff};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, psm = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic [4:0] pin_in = 5'h00, gpio_out = 5'h00, pin_out, pin_oe_n, gpio_in;
  logic [16:0] src = 17'h00000;
  logic [3:0] cnt;
  wire [11:0] fo;
  int n_fail = 0, n_compared = 0;
  gmx_pin_mux #(.MASK_DEFAULT_B(DEF_B), .MASK_DEFAULT_C(DEF_C)) i_gmx_pin_mux (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .psm_reset_req(psm), .pin_in, .pin_out, .pin_oe_n, .gpio_out, .gpio_in,
    .device_clock(src[0]), .adc_frame_clock(src[1]), .clk_32k(src[2]),
    .battery_fault_n(src[3]), .mic_short(src[4]), .adc_data_avail(src[5]),
    .codec_output_clock(src[6]), .conv5_undervoltage(src[7]), .conv5_clock(src[8]),
    .mic_detect(src[9]), .memory_reset_n(src[10]), .flash_out(src[11]),
    .supply_fault_n(src[12]), .rtc_signal(src[13]), .line_above_battery(src[14]),
    .reset_n(src[15]), .adc_bit_clock(src[16]),
    .low_power_req_one(fo[0]), .low_power_req_two(fo[1]), .flash_trigger(fo[2]),
    .hibernate_level(fo[3]), .power_off_req(fo[4]), .manual_reset_n(fo[5]),
    .mask_req(fo[6]), .chip_reset_req(fo[7]), .host_alive_pulse(fo[8]),
    .adc_frame_clock_in(fo[9]), .adc_bit_clock_in(fo[10]), .hibernate_edge(fo[11]));
  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  task complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Outputs are read at the edge, before that edge's updates land
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    check("answer", n < 20, 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'h0, a, 32'h0);
    check("read data", r, x);
    check("slave error", e, xe);
  endtask
  task pad(input logic [27:0] t, input logic v);
    cnt = 4'h0;
    pin_in <= v ? 5'h01 << t[7:4] : 5'h00;
    repeat (6) begin
      @(posedge pclk);
      cnt += fo[11];
    end
    check("function", fo[t[3:0]], t[3:0] == 4'hb ? 1'h0 : v);
    check("edge events", cnt, v && t[3:0] == 4'hb);
  endtask
  task drive(input logic [31:0] t, input logic v);
    logic gp;
    gp = t[7:0] == 8'hff;
    src <= gp ? {17{~v}} : (17'h00001 << t[4:0]) ^ {17{~v}};
    gpio_out <= {5{gp ~^ v}};
    repeat (4) @(posedge pclk);
    check("pin output", pin_out[t[11:8]], v ^ (t[7] & !gp));
  endtask
  initial begin
    forever #5 pclk = ~pclk;
  end
  initial begin
    #300000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(`GMX_ADDR_SEL_B, DEF_B, 1'h0);
    rd(`GMX_ADDR_SEL_C, DEF_C, 1'h0);
    apb(1'h1, `GMX_ADDR_SEL_B, 32'hffffa5c3);
    apb(1'h1, `GMX_ADDR_SEL_C, 32'h00009876);
    rd(`GMX_ADDR_SEL_B, 32'h0000a5c3, 1'h0);
    rd(`GMX_ADDR_SEL_C, 32'h00009876, 1'h0);
    psm <= 1'h1;
    @(posedge pclk);
    psm <= 1'h0;
    rd(`GMX_ADDR_SEL_B, DEF_B, 1'h0);
    rd(`GMX_ADDR_SEL_C, DEF_C, 1'h0);
    rd(12'h100, 32'h0, 1'h1);
    pin_in <= 5'h15;
    repeat (4) @(posedge pclk);
    rd(`GMX_ADDR_DIR, 32'h00001500, 1'h0);
    check("pad level", gpio_in, 5'h15);
    foreach (TI[i]) begin
      apb(1'h1, TI[i][24] ? `GMX_ADDR_SEL_C : `GMX_ADDR_SEL_B, {16'h0, TI[i][23:8]});
      pad(TI[i], 1'h1);
      pad(TI[i], 1'h0);
    end
    apb(1'h1, `GMX_ADDR_DIR, 32'h0000001f);
    repeat (3) @(posedge pclk);
    check("output enable", pin_oe_n, 5'h00);
    foreach (TO[i]) begin
      apb(1'h1, TO[i][28] ? `GMX_ADDR_SEL_C : `GMX_ADDR_SEL_B, {16'h0, TO[i][27:12]});
      drive(TO[i], 1'h1);
      drive(TO[i], 1'h0);
    end
    // A driven pin must not feed its input function
    apb(1'h1, `GMX_ADDR_SEL_B, 32'h00000002);
    pin_in <= 5'h01;
    repeat (4) @(posedge pclk);
    check("pad level", gpio_in, 5'h01);
    check("function of driven pin", fo[2], 1'h0);
    // Reload while pads are driven must release them
    pin_in <= 5'h00;
    psm <= 1'h1;
    @(posedge pclk);
    psm <= 1'h0;
    repeat (2) @(posedge pclk);
    check("released pads", pin_oe_n, 5'h1f);
    rd(`GMX_ADDR_DIR, 32'h00000000, 1'h0);
    rd(`GMX_ADDR_SEL_B, DEF_B, 1'h0);
    complete_run;
  end
endmodule
